//--- core/ssps_pkg.sv
// Constants and types shared by the dual serial slave port of the sensor
package ssps_pkg;

  // ---------------------------------------------------------------
  // Byte framing
  // ---------------------------------------------------------------
  localparam int unsigned BYTE_BITS  = 8;
  localparam logic [2:0]  BIT_LAST   = 3'h7;    // Index of eighth clock in a byte
  localparam int unsigned CMD_FLAG_B = 7;       // 1 = command byte, 0 = data byte
  localparam int unsigned RD_FLAG_B  = 6;       // 1 = read, 0 = write
  localparam int unsigned ADDR_HI_B  = 5;
  localparam int unsigned ADDR_LO_B  = 2;

  // ---------------------------------------------------------------
  // Register address map (content lives outside this block)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_STATUS   = 4'h0;
  localparam logic [3:0] ADDR_WR_FIRST = 4'h1;  // First writable register
  localparam logic [3:0] ADDR_WR_LAST  = 4'h6;  // Last writable register

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [2:0] CNT_RST   = 3'h0;
  localparam logic [3:0] ADDR_RST  = 4'h0;
  localparam logic       MISO_RST  = 1'b1;      // High after reset, sleep or scan; between bytes the line holds the last bit sent
  localparam logic       IRQ_N_RST = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SLEEP = 2'b00,     // Reset/sleep pin held high
    ST_CMD   = 2'b01,     // Expecting a command byte
    ST_DATA  = 2'b10,     // Data byte following a command
    ST_SCAN  = 2'b11      // Factory scan test, left only by reset
  } ssps_state_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] addr;
    logic [6:0] data;
  } ssps_wr_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ssps_byte_t;

endpackage

//--- core/ssps_port.sv
// Dual serial slave port: slow control port and fast image port
`timescale 1ns/10ps

module ssps_port
  import ssps_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_reset_sleep,        // Reset/sleep pin, active high
  input  wire logic       i_sck,
  input  wire logic       i_mosi,
  input  wire logic       i_slow_port_select_n,
  input  wire logic       i_fast_port_select_n,
  input  wire logic [7:0] i_reg_rdata,          // Register read data for o_reg_addr
  input  wire logic [7:0] i_pix_data,           // Next image byte for the fast port
  input  wire logic       i_irq_event,          // One-cycle event from the core
  output logic            o_miso,
  output logic            o_irq_n,
  output logic            o_sleep,
  output logic            o_scan_test,
  output logic [3:0]      o_reg_addr,
  output ssps_wr_t        o_reg_wr,
  output logic            o_status_rd,
  output logic            o_pix_ack,
  output ssps_byte_t      o_fast_rx
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ssps_state_t state_r, state_nxt;
  logic [2:0]  cnt_r, cnt_nxt;
  logic [7:0]  rx_r, rx_nxt;
  logic [7:0]  tx_r, tx_nxt;
  logic        sck_d_r, sck_d_nxt;
  logic        rd_r, rd_nxt;
  logic [3:0]  addr_r, addr_nxt;
  logic        miso_r, miso_nxt;
  logic        irq_n_r, irq_n_nxt;
  logic        sleep_r, sleep_nxt;
  logic        scan_r, scan_nxt;
  ssps_wr_t    wr_r, wr_nxt;
  logic        stat_rd_r, stat_rd_nxt;
  logic        pix_ack_r, pix_ack_nxt;
  ssps_byte_t  frx_r, frx_nxt;

  logic        sel_slow;
  logic        sel_fast;
  logic        sck_rise;
  logic        sck_fall;
  logic [7:0]  rx_byte;
  logic [7:0]  load_byte;

  // Port decode: clock and data count only with exactly one select low
  assign sel_slow = ~i_slow_port_select_n & i_fast_port_select_n;
  assign sel_fast = ~i_fast_port_select_n & i_slow_port_select_n;
  // Clock idles high, so each bit opens on a falling edge; only rising edges are counted
  assign sck_rise = i_sck & ~sck_d_r;
  assign sck_fall = ~i_sck & sck_d_r;
  assign rx_byte  = {rx_r[6:0], i_mosi};

  // ---------------------------------------------------------------
  // Byte offered at the start of each transfer
  // ---------------------------------------------------------------
  // Slow port answers only in the data slot after a read command
  always_comb begin
    load_byte = SHIFT_RST;
    if (sel_fast) begin
      load_byte = i_pix_data;
    end else if (state_r == ST_DATA && rd_r) begin
      load_byte = i_reg_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    rx_nxt      = rx_r;
    tx_nxt      = tx_r;
    sck_d_nxt   = i_sck;
    rd_nxt      = rd_r;
    addr_nxt    = addr_r;
    miso_nxt    = miso_r;
    irq_n_nxt   = irq_n_r;
    sleep_nxt   = 1'b0;
    scan_nxt    = scan_r;
    wr_nxt      = '0;
    stat_rd_nxt = 1'b0;
    pix_ack_nxt = 1'b0;
    frx_nxt     = '0;

    if (i_reset_sleep) begin
      // Pin reset brings the bit counter back into byte alignment, as i_rst_b does
      state_nxt = ST_SLEEP;
      sleep_nxt = 1'b1;
      cnt_nxt   = CNT_RST;
      rx_nxt    = SHIFT_RST;
      tx_nxt    = SHIFT_RST;
      rd_nxt    = 1'b0;
      addr_nxt  = ADDR_RST;
      miso_nxt  = MISO_RST;
      irq_n_nxt = IRQ_N_RST;
      scan_nxt  = 1'b0;
    end else if (state_r == ST_SCAN) begin
      // Scan test holds until the reset pin; serial ports stay deaf
      scan_nxt = 1'b1;
      miso_nxt = MISO_RST;
    end else if (~i_slow_port_select_n & ~i_fast_port_select_n) begin
      state_nxt = ST_SCAN;
      scan_nxt  = 1'b1;
      miso_nxt  = MISO_RST;
    end else begin
      if (state_r == ST_SLEEP) begin
        state_nxt = ST_CMD;
      end

      // Falling edge launches the next bit, MSB first
      if ((sel_slow | sel_fast) && sck_fall) begin
        if (cnt_r == CNT_RST) begin
          miso_nxt = load_byte[7];
          tx_nxt   = {load_byte[6:0], 1'b0};
        end else begin
          miso_nxt = tx_r[7];
          tx_nxt   = {tx_r[6:0], 1'b0};
        end
      end

      // Rising edge samples; the counter survives a deselect on purpose
      if ((sel_slow | sel_fast) && sck_rise) begin
        rx_nxt  = rx_byte;
        cnt_nxt = 3'(cnt_r + 3'h1);
        if (cnt_r == BIT_LAST) begin
          if (sel_fast) begin
            pix_ack_nxt   = 1'b1;
            frx_nxt.valid = 1'b1;
            frx_nxt.data  = rx_byte;
          end else if (rx_byte[CMD_FLAG_B]) begin
            // Command byte: latch direction and address
            state_nxt = ST_DATA;
            rd_nxt    = rx_byte[RD_FLAG_B];
            addr_nxt  = rx_byte[ADDR_HI_B:ADDR_LO_B];
          end else if (state_r == ST_DATA) begin
            state_nxt = ST_CMD;
            if (rd_r) begin
              // Status read hands the event back to the host
              stat_rd_nxt = (addr_r == ADDR_STATUS);
            end else if (addr_r >= ADDR_WR_FIRST && addr_r <= ADDR_WR_LAST) begin
              wr_nxt.valid = 1'b1;
              wr_nxt.addr  = addr_r;
              wr_nxt.data  = rx_byte[6:0];
            end
          end
        end
      end

      // Interrupt: a new event wins over the status-read clear
      if (i_irq_event) begin
        irq_n_nxt = 1'b0;
      end else if (stat_rd_r) begin
        irq_n_nxt = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_r   <= ST_SLEEP;
      cnt_r     <= CNT_RST;
      rx_r      <= SHIFT_RST;
      tx_r      <= SHIFT_RST;
      sck_d_r   <= 1'b1;
      rd_r      <= 1'b0;
      addr_r    <= ADDR_RST;
      miso_r    <= MISO_RST;
      irq_n_r   <= IRQ_N_RST;
      sleep_r   <= 1'b1;
      scan_r    <= 1'b0;
      wr_r      <= '0;
      stat_rd_r <= 1'b0;
      pix_ack_r <= 1'b0;
      frx_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      rx_r      <= rx_nxt;
      tx_r      <= tx_nxt;
      sck_d_r   <= sck_d_nxt;
      rd_r      <= rd_nxt;
      addr_r    <= addr_nxt;
      miso_r    <= miso_nxt;
      irq_n_r   <= irq_n_nxt;
      sleep_r   <= sleep_nxt;
      scan_r    <= scan_nxt;
      wr_r      <= wr_nxt;
      stat_rd_r <= stat_rd_nxt;
      pix_ack_r <= pix_ack_nxt;
      frx_r     <= frx_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------
  assign o_miso      = miso_r;
  assign o_irq_n     = irq_n_r;
  assign o_sleep     = sleep_r;
  assign o_scan_test = scan_r;
  assign o_reg_addr  = addr_r;
  assign o_reg_wr    = wr_r;
  assign o_status_rd = stat_rd_r;
  assign o_pix_ack   = pix_ack_r;
  assign o_fast_rx   = frx_r;

endmodule

//--- dv/ssps_props.sv
// Assertion checker for the dual serial slave port
`timescale 1ns/10ps

module ssps_props
  import ssps_pkg::*;
(
  input wire logic       i_mclk,
  input wire logic       i_rst_b,
  input wire logic       i_reset_sleep,
  input wire logic       i_sck,
  input wire logic       i_slow_port_select_n,
  input wire logic       i_fast_port_select_n,
  input wire logic       i_irq_event,
  input wire logic       o_miso,
  input wire logic       o_irq_n,
  input wire logic       o_sleep,
  input wire logic       o_scan_test,
  input wire ssps_wr_t   o_reg_wr,
  input wire logic       o_status_rd,
  input wire logic       o_pix_ack,
  input wire ssps_byte_t o_fast_rx
);
  // ------------------------------------------------------------
  // Port relations, all in the system clock domain
  // ------------------------------------------------------------
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);

  property p_irq_set;
    i_irq_event && !i_reset_sleep |=> !o_irq_n;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("irq not raised");

  property p_irq_clr;
    o_status_rd && !i_irq_event |=> o_irq_n;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq not cleared");

  property p_sleep;
    i_reset_sleep |=> o_sleep && o_irq_n && o_miso && !o_scan_test;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not forced");

  property p_scan;
    !o_sleep && !i_reset_sleep && !i_slow_port_select_n && !i_fast_port_select_n
      |=> o_scan_test;
  endproperty
  a_scan: assert property (p_scan) else $error("scan not entered");

  property p_scan_keep;
    o_scan_test && !i_reset_sleep |=> o_scan_test;
  endproperty
  a_scan_keep: assert property (p_scan_keep) else $error("scan left");

  property p_wr_rng;
    o_reg_wr.valid |-> o_reg_wr.addr inside {[ADDR_WR_FIRST:ADDR_WR_LAST]};
  endproperty
  a_wr_rng: assert property (p_wr_rng) else $error("write to read-only");

  // A write strobe follows a sampled rise with only the slow port selected
  property p_wr_edge;
    o_reg_wr.valid |-> $past(i_sck) && !$past(i_sck, 2) && !$past(i_slow_port_select_n)
      && $past(i_fast_port_select_n);
  endproperty
  a_wr_edge: assert property (p_wr_edge) else $error("write strobe timing");

  property p_pix;
    o_pix_ack |-> o_fast_rx.valid && $past(i_sck) && !$past(i_fast_port_select_n)
      && $past(i_slow_port_select_n);
  endproperty
  a_pix: assert property (p_pix) else $error("fast byte timing");

  // Output data may move only just after a sampled fall, a sleep request or both selects low
  property p_miso;
    $changed(o_miso) |-> $past(i_reset_sleep) || (!$past(i_sck) && $past(i_sck, 2))
      || (!$past(i_slow_port_select_n) && !$past(i_fast_port_select_n));
  endproperty
  a_miso: assert property (p_miso) else $error("miso moved off fall");
endmodule

bind ssps_port ssps_props u_props (.i_mclk, .i_rst_b, .i_reset_sleep, .i_sck,
  .i_slow_port_select_n, .i_fast_port_select_n, .i_irq_event, .o_miso, .o_irq_n,
  .o_sleep, .o_scan_test, .o_reg_wr, .o_status_rd, .o_pix_ack, .o_fast_rx);

//--- dv/ssps_host.sv
// Host serial master model: clock, selects and data for both ports
`timescale 1ns/10ps

module ssps_host (
  input  wire logic i_mclk,
  input  wire logic i_miso,
  output logic      o_sck,
  output logic      o_mosi,
  output logic      o_slow_sel_n,
  output logic      o_fast_sel_n
);
  // Lines rest at pull-up level; clock idles high
  initial begin
    o_sck        = 1'b1;
    o_mosi       = 1'b1;
    o_slow_sel_n = 1'b1;
    o_fast_sel_n = 1'b1;
  end

  // Half serial periods in system clocks. Slow: 63 x 40 ns keeps the rate under 200 kHz.
  // Fast: the sampled clock needs two system clocks a half, so its 8 MHz floor is out of reach
  localparam int SLOW_HALF = 63;
  localparam int FAST_HALF = 3;

  task automatic half(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // One access on one port; n below eight only to knock the device out of step
  task automatic xfer(input logic fast, input logic [7:0] tx, input int n,
                      output logic [7:0] rx);
    int h;
    rx           = 8'h00;
    h            = fast ? FAST_HALF : SLOW_HALF;
    o_slow_sel_n = fast;
    o_fast_sel_n = !fast;
    half(h);
    for (int i = 0; i < n; i++) begin
      o_sck  = 1'b0;
      o_mosi = tx[7-i];
      half(h);
      o_sck = 1'b1;
      rx    = {rx[6:0], i_miso};
      half(h);
    end
    o_slow_sel_n = 1'b1;
    o_fast_sel_n = 1'b1;
    o_mosi       = 1'b1;
    half(h);
  endtask

  // Deliberate fault: both selects low together
  task automatic both_low();
    o_slow_sel_n = 1'b0;
    o_fast_sel_n = 1'b0;
    half(FAST_HALF);
    o_slow_sel_n = 1'b1;
    o_fast_sel_n = 1'b1;
    half(FAST_HALF);
  endtask
endmodule

//--- dv/testbench.sv
// Self-checking bench for the dual serial slave port
`timescale 1ns/10ps

module testbench;
  import ssps_pkg::*;

  // ------------------------------------------------------------
  // Stimulus, monitors and counters
  // ------------------------------------------------------------
  logic       i_mclk  = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       slp     = 1'b1;
  logic       irq_ev  = 1'b0;
  logic [7:0] rdata   = 8'h00;
  logic [7:0] pix     = 8'h00;
  logic       sck, mosi, ssel_n, fsel_n, miso, irq_n, sleep, scan, st_rd, ack;
  logic [3:0] addr;
  logic [7:0] rx;
  ssps_wr_t   wr, wr_last;
  ssps_byte_t frx, fx_last;
  int         wr_cnt, st_cnt, cyc, bad_count, samples_checked;

  always #20 i_mclk = ~i_mclk;

  ssps_port u_ssps_port (.i_mclk, .i_rst_b, .i_reset_sleep(slp), .i_sck(sck),
    .i_mosi(mosi), .i_slow_port_select_n(ssel_n), .i_fast_port_select_n(fsel_n),
    .i_reg_rdata(rdata), .i_pix_data(pix), .i_irq_event(irq_ev), .o_miso(miso),
    .o_irq_n(irq_n), .o_sleep(sleep), .o_scan_test(scan), .o_reg_addr(addr),
    .o_reg_wr(wr), .o_status_rd(st_rd), .o_pix_ack(ack), .o_fast_rx(frx));

  ssps_host u_ssps_host (.i_mclk, .i_miso(miso), .o_sck(sck), .o_mosi(mosi),
    .o_slow_sel_n(ssel_n), .o_fast_sel_n(fsel_n));

  // Write and status-read strobes are counted and the fast byte caught as they pass; the cycle ceiling cuts a hang
  always @(posedge i_mclk) begin
    cyc++;
    if (wr.valid === 1'b1) begin
      wr_cnt++;
      wr_last = wr;
    end
    if (ack === 1'b1) fx_last = frx;
    if (st_rd === 1'b1) st_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("bad_count=%0d samples_checked=%0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask

  // Command byte then data byte on the slow port
  task automatic wr2(input logic [7:0] cmd, input logic [7:0] dat);
    u_ssps_host.xfer(1'b0, cmd, 8, rx);
    u_ssps_host.xfer(1'b0, dat, 8, rx);
  endtask

  task automatic pin_pulse();
    @(negedge i_mclk) slp = 1'b1;
    repeat (3) @(negedge i_mclk);
    slp = 1'b0;
    repeat (3) @(negedge i_mclk);
  endtask

  task automatic t_sleep();
    repeat (2) @(negedge i_mclk);
    chk("sleep", 12'h001, 12'(sleep));
    repeat (250) @(negedge i_mclk);
    slp = 1'b0;
    repeat (10) @(negedge i_mclk);
    chk("sleep", 12'h000, 12'(sleep));
  endtask

  // Low command bits are don't-care; addresses 0 and 7 take no write
  task automatic t_write();
    wr2(8'h87, 8'h2A);
    chk("reg_wr", {1'b1, 4'h1, 7'h2A}, wr_last);
    chk("reg_addr", 12'h001, 12'(addr));
    wr2(8'h80, 8'h7F);
    wr2(8'h9C, 8'h7F);
    chk("reg_addr", 12'h007, 12'(addr));
    chk("wr_cnt", 12'h001, 12'(wr_cnt));
  endtask

  task automatic t_irq();
    rdata  = 8'hA5;
    irq_ev = 1'b1;
    @(negedge i_mclk) irq_ev = 1'b0;
    chk("irq_n", 12'h000, 12'(irq_n));
    wr2(8'hC0, 8'h00);
    chk("miso", 12'h0A5, 12'(rx));
    chk("st_cnt", 12'h001, 12'(st_cnt));
    chk("irq_n", 12'h001, 12'(irq_n));
  endtask

  task automatic t_fast();
    pix = 8'h96;
    u_ssps_host.xfer(1'b1, 8'h3C, 8, rx);
    chk("fast_rx", {3'h0, 1'b1, 8'h3C}, 12'(fx_last));
    chk("fast_miso", 12'h096, 12'(rx));
    chk("wr_cnt", 12'h001, 12'(wr_cnt));
  endtask

  // Seven clocks leave the write out of step until the reset pin is pulsed
  task automatic t_misalign();
    u_ssps_host.xfer(1'b0, 8'hFF, 7, rx);
    wr2(8'h84, 8'h05);
    chk("wr_cnt", 12'h001, 12'(wr_cnt));
    pin_pulse();
    wr2(8'h84, 8'h05);
    chk("reg_wr", {1'b1, 4'h1, 7'h05}, wr_last);
  endtask

  task automatic t_scan();
    u_ssps_host.both_low();
    chk("scan", 12'h001, 12'(scan));
    pin_pulse();
    chk("scan", 12'h000, 12'(scan));
  endtask

  initial begin
    repeat (5) @(negedge i_mclk);
    i_rst_b = 1'b1;
    t_sleep();
    t_write();
    t_irq();
    t_fast();
    t_misalign();
    t_scan();
    stop_test();
  end
endmodule
